// ===== verilog/csb_device.sv
// Core end: bus arbitration, snoop, coprocessor handshake, resets and straps.
//
// Notes on behaviour
// - Low-priority main request answered by low grant.
// - High-priority main request wins over low priority.
// - Snoop request answered by snoop grant.
// - High-priority snoop request wins over low one.
// - Master confirms ownership after gaining bus.
// - Core asserts release request; master gives up.
// - Snoop address valid only while snoop-valid asserted.
// - Snoop ignored while any main grant asserted.
// - Coprocessor read strobe ends on read acknowledge.
// - Coprocessor write strobe ends on write acknowledge.
// - Condition bits 3..1 serve coprocessors 3..1.
// - Bus clock restarts aligned to cold reset release.
// - Warm reset resets logic and raises reset exception.
// - Non-maskable interrupt input raises its exception.
// - Any of six interrupt lines raises interrupt.
// - Ratio strap selects divide by 2,3,4,1.
// - Timer-disable strap high blocks the timer interrupt.
// - Halt and doze outputs mirror control bits.
// - Endian strap at reset: high means big.
// - Bus-width strap high 32 bits, low 64.
// - Output-disable low drops the interface output enable; no output is floated.
// - Bus-start asserted only in operation's first clock.
`timescale 1ns/1ns
`include "csb_defines.svh"
module csb_device
(
    input wire logic i_clk,
    input wire logic i_rst,
    csb_if.dev bus,
    input wire logic i_cold_reset_n,
    input wire logic i_warm_reset_n,
    input wire logic i_nonmaskable_irq_n,
    input wire logic [`CSB_IRQ_N-1:0] i_irq_lines_n,
    input wire logic [`CSB_RATIO_W-1:0] i_bus_clock_ratio,
    input wire logic i_timer_irq_disable,
    input wire logic i_endian_strap,
    input wire logic i_bus_width_strap,
    input wire logic i_output_disable,
    input wire logic i_halt_bit,
    input wire logic i_doze_bit,
    input wire logic i_timer_tick,
    input wire logic i_core_bus_need,
    input wire logic i_cop_rd_start,
    input wire logic i_cop_wr_start,
    input wire logic i_mem_op_start,
    output logic o_halt_status,
    output logic o_doze_status,
    output logic o_exc_reset,
    output logic o_exc_nmi,
    output logic o_irq_pending,
    output logic o_timer_irq,
    output logic o_big_endian,
    output logic o_bus_32bit,
    output logic o_master_owns,
    output logic o_snoop_hit,
    output logic [`CSB_ADDR_W-1:0] o_snoop_addr,
    output logic o_cop_busy,
    output logic o_cop_done,
    output logic [`CSB_COND_W:1] o_cop_condition
);
    typedef struct packed
    {
        csb_pkg::csb_arb_e arb;
        logic gnt_lo_n;
        logic gnt_hi_n;
        logic sgnt_lo_n;
        logic sgnt_hi_n;
        logic rel_n;
        logic owned;
        logic snoop_hit;
        csb_pkg::csb_addr_t snoop_addr;
        logic rd_pend;
        logic wr_pend;
        logic rd_n;
        logic wr_n;
        logic cop_done;
        logic [`CSB_COND_W:1] cond;
        logic bs_pend;
        logic bstart_n;
        logic halt;
        logic doze;
        logic exc_reset;
        logic exc_nmi;
        logic irq_pend;
        logic timer_irq;
        logic warm_q;
        logic nmi_q;
        logic big_endian;
        logic bus32;
        logic [`CSB_RATIO_W-1:0] ratio;
    } csb_dev_s;

    csb_dev_s st;
    csb_dev_s next_st;
    logic tick;
    logic want_lo;
    logic want_hi;
    logic want_slo;
    logic want_shi;

    // ------------------------------------------------------------
    // Bus clock enable.
    // ------------------------------------------------------------
    // Held in cold reset so the first tick follows its release.
    csb_clk_div u_div
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_hold(~i_cold_reset_n),
        .i_ratio(st.ratio),
        .o_tick(tick)
    );

    // Request decode of the active-low pins.
    assign want_lo = ~bus.main_bus_req_lo_n;
    assign want_hi = ~bus.main_bus_req_hi_n;
    assign want_slo = ~bus.snoop_bus_req_lo_n;
    assign want_shi = ~bus.snoop_bus_req_hi_n;

    // ------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------
    // Arbitration and handshakes advance only on bus ticks.
    always_comb
    begin
        next_st = st;
        next_st.snoop_hit = 1'b0;
        next_st.cop_done = 1'b0;
        next_st.exc_reset = 1'b0;
        next_st.exc_nmi = 1'b0;
        next_st.warm_q = i_warm_reset_n;
        next_st.nmi_q = i_nonmaskable_irq_n;
        next_st.halt = i_halt_bit;
        next_st.doze = i_doze_bit;
        next_st.irq_pend = ~(&i_irq_lines_n);
        next_st.timer_irq = i_timer_tick & ~i_timer_irq_disable;
        // A falling non-maskable line gives one exception pulse.
        if (!i_nonmaskable_irq_n && st.nmi_q)
        begin
            next_st.exc_nmi = 1'b1;
        end
        // Straps latch while cold reset is held.
        if (!i_cold_reset_n)
        begin
            next_st.big_endian = i_endian_strap;
            next_st.bus32 = i_bus_width_strap;
            next_st.ratio = i_bus_clock_ratio;
        end
        // Start requests wait for the next bus tick.
        if (i_cop_rd_start && st.rd_n && st.wr_n && !st.wr_pend)
        begin
            next_st.rd_pend = 1'b1;
        end
        else if (i_cop_wr_start && st.rd_n && st.wr_n && !st.rd_pend)
        begin
            next_st.wr_pend = 1'b1;
        end
        if (i_mem_op_start)
        begin
            next_st.bs_pend = 1'b1;
        end
        if (tick)
        begin
            // Bus start lasts exactly one bus clock.
            next_st.bstart_n = ~st.bs_pend;
            next_st.bs_pend = i_mem_op_start;
            next_st.cond = bus.copro_condition;
            // Arbitration, high priority first.
            case (st.arb)
                csb_pkg::CSB_IDLE:
                begin
                    next_st.owned = 1'b0;
                    if (!i_core_bus_need)
                    begin
                        if (want_hi)
                            next_st.arb = csb_pkg::CSB_GNT_HI;
                        else if (want_lo)
                            next_st.arb = csb_pkg::CSB_GNT_LO;
                        else if (want_shi)
                            next_st.arb = csb_pkg::CSB_SGNT_HI;
                        else if (want_slo)
                            next_st.arb = csb_pkg::CSB_SGNT_LO;
                    end
                end
                csb_pkg::CSB_GNT_LO:
                    if (!want_lo) next_st.arb = csb_pkg::CSB_IDLE;
                csb_pkg::CSB_GNT_HI:
                    if (!want_hi) next_st.arb = csb_pkg::CSB_IDLE;
                csb_pkg::CSB_SGNT_LO:
                    if (!want_slo) next_st.arb = csb_pkg::CSB_IDLE;
                csb_pkg::CSB_SGNT_HI:
                    if (!want_shi) next_st.arb = csb_pkg::CSB_IDLE;
                default:
                    next_st.arb = csb_pkg::CSB_IDLE;
            endcase
            // Ownership is confirmed while a grant stands.
            if (st.arb != csb_pkg::CSB_IDLE && !bus.ownership_confirm_n)
            begin
                next_st.owned = 1'b1;
            end
            // Release request while the core needs the bus.
            next_st.rel_n = ~(i_core_bus_need && next_st.arb != csb_pkg::CSB_IDLE);
            // Snoop lookups only outside main grants.
            if (!bus.snoop_valid_n && st.gnt_lo_n && st.gnt_hi_n)
            begin
                next_st.snoop_hit = 1'b1;
                next_st.snoop_addr = bus.bus_address;
            end
            // Coprocessor strobes end on their acknowledge.
            if (!st.rd_n && !bus.copro_read_ack_n)
            begin
                next_st.rd_n = `CSB_IDLE_N;
                next_st.cop_done = 1'b1;
            end
            else if (st.rd_pend)
            begin
                next_st.rd_n = `CSB_ASSERT_N;
                next_st.rd_pend = 1'b0;
            end
            if (!st.wr_n && !bus.copro_write_ack_n)
            begin
                next_st.wr_n = `CSB_IDLE_N;
                next_st.cop_done = 1'b1;
            end
            else if (st.wr_pend)
            begin
                next_st.wr_n = `CSB_ASSERT_N;
                next_st.wr_pend = 1'b0;
            end
        end
        // Warm reset returns bus logic to idle and raises the exception.
        if (!i_warm_reset_n)
        begin
            next_st.arb = csb_pkg::CSB_IDLE;
            next_st.owned = 1'b0;
            next_st.rel_n = `CSB_IDLE_N;
            next_st.rd_n = `CSB_IDLE_N;
            next_st.wr_n = `CSB_IDLE_N;
            next_st.rd_pend = 1'b0;
            next_st.wr_pend = 1'b0;
            next_st.bs_pend = 1'b0;
            next_st.bstart_n = `CSB_IDLE_N;
            next_st.exc_reset = st.warm_q;
        end
        // Grant pins follow the arbitration state.
        next_st.gnt_lo_n = (next_st.arb != csb_pkg::CSB_GNT_LO);
        next_st.gnt_hi_n = (next_st.arb != csb_pkg::CSB_GNT_HI);
        next_st.sgnt_lo_n = (next_st.arb != csb_pkg::CSB_SGNT_LO);
        next_st.sgnt_hi_n = (next_st.arb != csb_pkg::CSB_SGNT_HI);
    end

    // Registers the whole state, active-low pins idle high.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st <= '0;
            st.gnt_lo_n <= `CSB_IDLE_N;
            st.gnt_hi_n <= `CSB_IDLE_N;
            st.sgnt_lo_n <= `CSB_IDLE_N;
            st.sgnt_hi_n <= `CSB_IDLE_N;
            st.rel_n <= `CSB_IDLE_N;
            st.rd_n <= `CSB_IDLE_N;
            st.wr_n <= `CSB_IDLE_N;
            st.bstart_n <= `CSB_IDLE_N;
            st.warm_q <= `CSB_IDLE_N;
            st.nmi_q <= `CSB_IDLE_N;
            st.ratio <= `CSB_RST_RATIO;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    // Link pins; the enable goes out on the interface, which does not float them.
    assign bus.out_en = i_output_disable;
    assign bus.bus_tick = tick;
    assign bus.main_bus_gnt_lo_n = st.gnt_lo_n;
    assign bus.main_bus_gnt_hi_n = st.gnt_hi_n;
    assign bus.snoop_bus_gnt_lo_n = st.sgnt_lo_n;
    assign bus.snoop_bus_gnt_hi_n = st.sgnt_hi_n;
    assign bus.release_request_n = st.rel_n;
    assign bus.copro_read_n = st.rd_n;
    assign bus.copro_write_n = st.wr_n;
    assign bus.bus_op_start_n = st.bstart_n;
    // User-side status.
    assign o_halt_status = st.halt;
    assign o_doze_status = st.doze;
    assign o_exc_reset = st.exc_reset;
    assign o_exc_nmi = st.exc_nmi;
    assign o_irq_pending = st.irq_pend;
    assign o_timer_irq = st.timer_irq;
    assign o_big_endian = st.big_endian;
    assign o_bus_32bit = st.bus32;
    assign o_master_owns = st.owned;
    assign o_snoop_hit = st.snoop_hit;
    assign o_snoop_addr = st.snoop_addr;
    assign o_cop_busy = st.rd_pend | st.wr_pend | ~st.rd_n | ~st.wr_n;
    assign o_cop_done = st.cop_done;
    assign o_cop_condition = st.cond;
endmodule

// ===== verilog/csb_defines.svh
// Constants shared by both ends of the core sideband arbitration link.
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH
`define CSB_ADDR_W 36
`define CSB_IRQ_N 6
`define CSB_COND_W 3
`define CSB_RATIO_W 2
`define CSB_RATIO_DIV2 2'h0
`define CSB_RATIO_DIV3 2'h1
`define CSB_RATIO_DIV4 2'h2
`define CSB_RATIO_DIV1 2'h3
`define CSB_DIVISOR_2 3'h2
`define CSB_DIVISOR_3 3'h3
`define CSB_DIVISOR_4 3'h4
`define CSB_DIVISOR_1 3'h1
`define CSB_CNT_ONE 3'h1
`define CSB_CNT_W 3
`define CSB_RST_RATIO 2'h0
`define CSB_IDLE_N 1'h1
`define CSB_ASSERT_N 1'h0
`endif

// ===== verilog/csb_pkg.sv
// Types for the core sideband arbitration link.
`include "csb_defines.svh"
package csb_pkg;
    typedef enum logic [2:0]
    {
        CSB_IDLE = 3'b000,
        CSB_GNT_LO = 3'b001,
        CSB_GNT_HI = 3'b010,
        CSB_SGNT_LO = 3'b011,
        CSB_SGNT_HI = 3'b100
    } csb_arb_e;
    typedef logic [`CSB_ADDR_W-1:0] csb_addr_t;
endpackage

// ===== verilog/csb_if.sv
// Interface joining the core end and the external bus master end.
`timescale 1ns/1ns
`include "csb_defines.svh"
interface csb_if;
    logic bus_tick;
    logic out_en;
    logic main_bus_req_lo_n;
    logic main_bus_req_hi_n;
    logic snoop_bus_req_lo_n;
    logic snoop_bus_req_hi_n;
    logic main_bus_gnt_lo_n;
    logic main_bus_gnt_hi_n;
    logic snoop_bus_gnt_lo_n;
    logic snoop_bus_gnt_hi_n;
    logic ownership_confirm_n;
    logic release_request_n;
    logic snoop_valid_n;
    logic bus_address_oe;
    logic [`CSB_ADDR_W-1:0] bus_address;
    logic copro_read_n;
    logic copro_write_n;
    logic copro_read_ack_n;
    logic copro_write_ack_n;
    logic [`CSB_COND_W:1] copro_condition;
    logic bus_op_start_n;
    modport dev
    (
        output bus_tick, out_en, main_bus_gnt_lo_n, main_bus_gnt_hi_n, snoop_bus_gnt_lo_n,
        output snoop_bus_gnt_hi_n, release_request_n, copro_read_n, copro_write_n, bus_op_start_n,
        input main_bus_req_lo_n, main_bus_req_hi_n, snoop_bus_req_lo_n, snoop_bus_req_hi_n,
        input ownership_confirm_n, snoop_valid_n, bus_address, bus_address_oe,
        input copro_read_ack_n, copro_write_ack_n, copro_condition
    );
    modport mst
    (
        input bus_tick, out_en, main_bus_gnt_lo_n, main_bus_gnt_hi_n, snoop_bus_gnt_lo_n,
        input snoop_bus_gnt_hi_n, release_request_n, copro_read_n, copro_write_n, bus_op_start_n,
        output main_bus_req_lo_n, main_bus_req_hi_n, snoop_bus_req_lo_n, snoop_bus_req_hi_n,
        output ownership_confirm_n, snoop_valid_n, bus_address, bus_address_oe,
        output copro_read_ack_n, copro_write_ack_n, copro_condition
    );
endinterface

// ===== verilog/csb_clk_div.sv
// Bus clock enable divider driven by the two-bit ratio strap.
`timescale 1ns/1ns
`include "csb_defines.svh"
module csb_clk_div
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hold,
    input wire logic [`CSB_RATIO_W-1:0] i_ratio,
    output logic o_tick
);
    typedef struct packed
    {
        logic [`CSB_CNT_W-1:0] cnt;
        logic tick;
    } csb_div_s;

    csb_div_s st;
    csb_div_s next_st;
    logic [`CSB_CNT_W-1:0] divisor;

    // ------------------------------------------------------------
    // Ratio decode and counting.
    // ------------------------------------------------------------
    // Maps the strap code onto a divisor of the core clock.
    always_comb
    begin
        case (i_ratio)
            `CSB_RATIO_DIV2: divisor = `CSB_DIVISOR_2;
            `CSB_RATIO_DIV3: divisor = `CSB_DIVISOR_3;
            `CSB_RATIO_DIV4: divisor = `CSB_DIVISOR_4;
            default: divisor = `CSB_DIVISOR_1;
        endcase
    end

    // Holding restarts the count; ticks align to its release.
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (i_hold)
        begin
            next_st.cnt = `CSB_CNT_ONE;
        end
        else if (st.cnt >= divisor)
        begin
            next_st.cnt = `CSB_CNT_ONE;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt + `CSB_CNT_ONE;
        end
    end

    // Registers the divider state.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;
endmodule

// ===== verilog/csb_master.sv
// Far end: external bus master and coprocessor acknowledge side.
`timescale 1ns/1ns
`include "csb_defines.svh"
module csb_master
(
    input wire logic i_clk,
    input wire logic i_rst,
    csb_if.mst bus,
    input wire logic i_want_main,
    input wire logic i_want_snoop,
    input wire logic i_high_prio,
    input wire logic i_snoop_go,
    input wire logic [`CSB_ADDR_W-1:0] i_snoop_addr,
    input wire logic i_cop_ready,
    input wire logic [`CSB_COND_W:1] i_cop_condition,
    output logic o_has_bus,
    output logic o_released
);
    typedef struct packed
    {
        logic req_lo_n;
        logic req_hi_n;
        logic sreq_lo_n;
        logic sreq_hi_n;
        logic confirm_n;
        logic snoop_n;
        csb_pkg::csb_addr_t addr;
        logic addr_oe;
        logic rd_ack_n;
        logic wr_ack_n;
        logic backoff;
        logic released;
        logic [`CSB_COND_W:1] cond;
    } csb_mst_s;

    csb_mst_s st;
    csb_mst_s next_st;
    logic granted;
    logic snoop_granted;

    assign snoop_granted = ~bus.snoop_bus_gnt_lo_n | ~bus.snoop_bus_gnt_hi_n;
    assign granted = ~bus.main_bus_gnt_lo_n | ~bus.main_bus_gnt_hi_n | snoop_granted;

    // ------------------------------------------------------------
    // Request, confirm and acknowledge logic on bus ticks.
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.released = 1'b0;
        next_st.cond = i_cop_condition;
        if (bus.bus_tick)
        begin
            // A release request makes the owner drop its request.
            if (granted && !bus.release_request_n)
            begin
                next_st.backoff = 1'b1;
                next_st.released = 1'b1;
            end
            else if (!granted)
            begin
                next_st.backoff = 1'b0;
            end
            next_st.req_hi_n = ~(i_want_main && i_high_prio && !next_st.backoff);
            next_st.req_lo_n = ~(i_want_main && !i_high_prio && !next_st.backoff);
            next_st.sreq_hi_n = ~(i_want_snoop && i_high_prio && !next_st.backoff);
            next_st.sreq_lo_n = ~(i_want_snoop && !i_high_prio && !next_st.backoff);
            next_st.confirm_n = ~(granted && !next_st.backoff);
            // Snoop addresses are driven only under a snoop grant.
            next_st.snoop_n = ~(snoop_granted && i_snoop_go && !next_st.backoff);
            next_st.addr_oe = ~next_st.snoop_n;
            next_st.addr = i_snoop_addr;
            // One-tick acknowledges when the coprocessor is ready.
            next_st.rd_ack_n = ~(!bus.copro_read_n && st.rd_ack_n && i_cop_ready);
            next_st.wr_ack_n = ~(!bus.copro_write_n && st.wr_ack_n && i_cop_ready);
        end
    end

    // Registers the state, active-low pins idle high.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st <= '0;
            st.req_lo_n <= `CSB_IDLE_N;
            st.req_hi_n <= `CSB_IDLE_N;
            st.sreq_lo_n <= `CSB_IDLE_N;
            st.sreq_hi_n <= `CSB_IDLE_N;
            st.confirm_n <= `CSB_IDLE_N;
            st.snoop_n <= `CSB_IDLE_N;
            st.rd_ack_n <= `CSB_IDLE_N;
            st.wr_ack_n <= `CSB_IDLE_N;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Link pins and user status.
    assign bus.main_bus_req_lo_n = st.req_lo_n;
    assign bus.main_bus_req_hi_n = st.req_hi_n;
    assign bus.snoop_bus_req_lo_n = st.sreq_lo_n;
    assign bus.snoop_bus_req_hi_n = st.sreq_hi_n;
    assign bus.ownership_confirm_n = st.confirm_n;
    assign bus.snoop_valid_n = st.snoop_n;
    assign bus.bus_address = st.addr;
    assign bus.bus_address_oe = st.addr_oe;
    assign bus.copro_read_ack_n = st.rd_ack_n;
    assign bus.copro_write_ack_n = st.wr_ack_n;
    assign bus.copro_condition = st.cond;
    assign o_has_bus = ~st.confirm_n;
    assign o_released = st.released;
endmodule

// ===== sim/csb_monitor.sv
// Checker for the arbitration and handshake signals of the sideband link.
`timescale 1ns/1ns
module csb_monitor
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic bus_tick,
    input wire logic main_bus_req_lo_n,
    input wire logic main_bus_req_hi_n,
    input wire logic snoop_bus_req_hi_n,
    input wire logic main_bus_gnt_lo_n,
    input wire logic main_bus_gnt_hi_n,
    input wire logic snoop_bus_gnt_lo_n,
    input wire logic snoop_bus_gnt_hi_n,
    input wire logic release_request_n,
    input wire logic copro_read_n,
    input wire logic copro_read_ack_n,
    input wire logic bus_op_start_n
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // The four grants as one vector.
    wire logic [3:0] gnt_n = {main_bus_gnt_lo_n, main_bus_gnt_hi_n, snoop_bus_gnt_lo_n,
        snoop_bus_gnt_hi_n};
    sequence s_start;
        $fell(bus_op_start_n);
    endsequence
    sequence s_rd_end;
        $rose(copro_read_n);
    endsequence
    property p_one_grant;
        $countones(~gnt_n) <= 1;
    endproperty
    a_one_grant: assert property (p_one_grant) else $error("two grants at once");
    property p_grant_tick;
        !$stable(gnt_n) |-> $past(bus_tick);
    endproperty
    a_grant_tick: assert property (p_grant_tick) else $error("grant moved off tick");
    property p_lo_cause;
        $fell(main_bus_gnt_lo_n) |-> !$past(main_bus_req_lo_n) && $past(main_bus_req_hi_n);
    endproperty
    a_lo_cause: assert property (p_lo_cause) else $error("bad low grant");
    property p_snoop_lo;
        $fell(snoop_bus_gnt_lo_n) |-> $past(snoop_bus_req_hi_n) && $past(main_bus_req_hi_n);
    endproperty
    a_snoop_lo: assert property (p_snoop_lo) else $error("bad snoop grant");
    property p_hold;
        !main_bus_gnt_hi_n && !main_bus_req_hi_n && bus_tick |=> !main_bus_gnt_hi_n;
    endproperty
    a_hold: assert property (p_hold) else $error("grant dropped early");
    property p_release;
        !release_request_n |-> gnt_n != 4'hf;
    endproperty
    a_release: assert property (p_release) else $error("release without grant");
    property p_rd_ack;
        s_rd_end |-> !$past(copro_read_ack_n);
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read ended without ack");
    property p_start;
        s_start |-> ##[1:4] $rose(bus_op_start_n);
    endproperty
    a_start: assert property (p_start) else $error("start held too long");
endmodule

// ===== sim/core_sideband_arbitration_if_test.sv
// Bench joining the core end and the bus master end of the sideband link.
`timescale 1ns/1ns
`include "csb_defines.svh"
module core_sideband_arbitration_if_test;
    logic i_clk, i_rst, i_cold_reset_n, i_warm_reset_n, i_nonmaskable_irq_n, i_output_disable;
    logic i_timer_irq_disable, i_endian_strap, i_bus_width_strap, i_halt_bit, i_doze_bit;
    logic i_timer_tick, i_core_bus_need, i_cop_rd_start, i_cop_wr_start, i_mem_op_start;
    logic i_want_main, i_want_snoop, i_high_prio, i_snoop_go, i_cop_ready, o_has_bus, o_released;
    logic o_halt_status, o_doze_status, o_exc_reset, o_exc_nmi, o_irq_pending, o_timer_irq;
    logic o_big_endian, o_bus_32bit, o_master_owns, o_snoop_hit, o_cop_busy, o_cop_done;
    logic [`CSB_IRQ_N-1:0] i_irq_lines_n;
    logic [`CSB_RATIO_W-1:0] i_bus_clock_ratio;
    logic [`CSB_ADDR_W-1:0] o_snoop_addr, i_snoop_addr;
    logic [`CSB_COND_W:1] o_cop_condition, i_cop_condition;
    int err_count, tests_run, n;
    // Inputs in bits 16:6, expected outputs in 5:0.
    logic [16:0] rows [4] = '{17'h1_4fea, 17'h0_bf95, 17'h1_e7ff, 17'h0_1fc0};
    int divs [4] = '{1, 4, 3, 2};
    csb_if bus_if ();
    csb_device i_csb_device
    (
        .*, .bus(bus_if.dev)
    );
    csb_master i_csb_master
    (
        .*, .bus(bus_if.mst)
    );
    csb_monitor u_mon
    (
        .i_clk, .i_rst, .bus_tick(bus_if.bus_tick), .main_bus_req_lo_n(bus_if.main_bus_req_lo_n),
        .main_bus_req_hi_n(bus_if.main_bus_req_hi_n),
        .snoop_bus_req_hi_n(bus_if.snoop_bus_req_hi_n),
        .main_bus_gnt_lo_n(bus_if.main_bus_gnt_lo_n), .main_bus_gnt_hi_n(bus_if.main_bus_gnt_hi_n),
        .snoop_bus_gnt_lo_n(bus_if.snoop_bus_gnt_lo_n),
        .snoop_bus_gnt_hi_n(bus_if.snoop_bus_gnt_hi_n),
        .release_request_n(bus_if.release_request_n), .copro_read_n(bus_if.copro_read_n),
        .copro_read_ack_n(bus_if.copro_read_ack_n), .bus_op_start_n(bus_if.bus_op_start_n)
    );
    task automatic check(string name, logic [35:0] exp, got);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bounded wait for a level on falling edges; returns on a rising edge.
    task automatic wait_for(ref logic s, input logic v, input string name);
        for (int k = 0; k < 80 && s !== v; k++)
            @(negedge i_clk);
        check(name, 36'(v), 36'(s));
        @(posedge i_clk);
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // 50 MHz core clock.
    initial
    begin
        i_clk = 1'h0;
        forever #10 i_clk = ~i_clk;
    end
    // Watchdog against a hang.
    initial
    begin
        #200000;
        err_count++;
        tally_and_finish();
    end
    // Table rows, then hand-written cases.
    initial
    begin
        {i_rst, i_warm_reset_n, i_nonmaskable_irq_n, i_output_disable, i_timer_tick} = 5'h1f;
        {i_cold_reset_n, i_timer_irq_disable, i_endian_strap, i_bus_width_strap} = 4'h0;
        {i_halt_bit, i_doze_bit, i_core_bus_need, i_cop_rd_start, i_cop_wr_start} = 5'h0;
        {i_mem_op_start, i_want_main, i_want_snoop, i_high_prio, i_snoop_go, i_cop_ready} = 6'h0;
        {i_irq_lines_n, i_bus_clock_ratio, i_snoop_addr, i_cop_condition} = {6'h3f, 41'h0};
        repeat (12) @(posedge i_clk);
        i_rst <= 1'h0;
        foreach (rows[r])
        begin
            @(posedge i_clk);
            {i_halt_bit, i_doze_bit, i_endian_strap, i_bus_width_strap, i_timer_irq_disable,
                i_irq_lines_n} <= rows[r][16:6];
            repeat (3) @(negedge i_clk);
            check("status", 36'(rows[r][5:0]), 36'({o_halt_status, o_doze_status, o_big_endian,
                o_bus_32bit, o_timer_irq, o_irq_pending}));
        end
        for (int k = 0; k < 4; k++)
        begin
            @(posedge i_clk);
            {i_cold_reset_n, i_bus_clock_ratio} <= {1'h0, 2'(3 - k)};
            repeat (3) @(posedge i_clk);
            i_cold_reset_n <= 1'h1;
            wait_for(bus_if.bus_tick, 1'h1, "first tick");
            n = 0;
            do
                @(negedge i_clk);
            while (++n < 9 && bus_if.bus_tick !== 1'h1);
            check("tick gap", 36'(divs[k]), 36'(n));
        end
        @(posedge i_clk);
        {i_want_main, i_high_prio} <= 2'h3;
        wait_for(bus_if.main_bus_gnt_hi_n, 1'h0, "hi grant");
        wait_for(o_master_owns, 1'h1, "owns");
        i_core_bus_need <= 1'h1;
        wait_for(bus_if.release_request_n, 1'h0, "release");
        wait_for(o_released, 1'h1, "backed off");
        i_want_main <= 1'h0;
        wait_for(bus_if.main_bus_gnt_hi_n, 1'h1, "hi grant back");
        {i_core_bus_need, i_high_prio, i_want_main} <= 3'h1;
        wait_for(bus_if.main_bus_gnt_lo_n, 1'h0, "lo grant");
        i_want_main <= 1'h0;
        wait_for(bus_if.main_bus_gnt_lo_n, 1'h1, "lo grant back");
        for (int k = 0; k < 2; k++)
        begin
            @(posedge i_clk);
            {i_want_snoop, i_high_prio, i_snoop_go} <= {1'h1, 1'(k), 1'h1};
            i_snoop_addr <= 36'h9_abcd_1234 + 36'(k);
            wait_for(o_snoop_hit, 1'h1, "snoop hit");
            check("snoop addr", 36'h9_abcd_1234 + 36'(k), o_snoop_addr);
            check("snoop gnt", 36'h0, 36'(k ? bus_if.snoop_bus_gnt_hi_n
                : bus_if.snoop_bus_gnt_lo_n));
            {i_want_snoop, i_snoop_go} <= 2'h0;
            wait_for(o_has_bus, 1'h0, "snoop dropped");
        end
        for (int k = 0; k < 2; k++)
        begin
            @(posedge i_clk);
            {i_cop_ready, i_cop_condition} <= {1'h1, 3'(5 - 3 * k)};
            {i_cop_rd_start, i_cop_wr_start, i_mem_op_start} <= {1'(k == 0), 1'(k == 1), 1'h1};
            @(posedge i_clk);
            {i_cop_rd_start, i_cop_wr_start, i_mem_op_start} <= 3'h0;
            wait_for(o_cop_busy, 1'h1, "cop busy");
            wait_for(o_cop_done, 1'h1, "cop done");
            check("condition", 36'(5 - 3 * k), 36'(o_cop_condition));
        end
        i_warm_reset_n <= 1'h0;
        wait_for(o_exc_reset, 1'h1, "reset exc");
        {i_warm_reset_n, i_nonmaskable_irq_n} <= 2'h2;
        wait_for(o_exc_nmi, 1'h1, "nmi exc");
        {i_nonmaskable_irq_n, i_output_disable} <= 2'h2;
        @(negedge i_clk);
        check("out enable", 36'h0, 36'(bus_if.out_en));
        tally_and_finish();
    end
endmodule
